// ==== hdl/cpal_port.sv ====
`timescale 1ns/10ps
`default_nettype none
// Operation
// - pixel index and blank are captured together on each rising clock edge.
// - the captured index selects one of 256 palette entries, bit 0 least significant.
// - a captured low blank forces all three colour outputs to the blanking level.
// - while blank was captured low the pixel index is disregarded.
// - the host holds the write strobe low and data is taken on its rising edge.
// - the two select inputs choose address register, palette or mask register, and the direction.
// - address and palette data move over one 8-bit two-way bus, bit 0 least significant.
// - select 00 writes address in write mode, 11 address in read mode, 01 palette, 10 mask.
// - palette writes are red, green, blue; on blue the 18-bit entry is stored, address steps.
// - colours sit in the low six bits; upper bits ignored on write, zero on read.
// - after a blue access at location FF the address wraps to 00.
module cpal_port
  import cpal_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [PIX_W-1:0] pixel_index_i,
  input  wire logic             blank_n_i,
  input  wire logic             rd_n_i,
  input  wire logic             wr_n_i,
  input  wire logic             reg_select_lo_i,
  input  wire logic             reg_select_hi_i,
  input  wire logic [7:0]       host_bus_i,
  output logic      [7:0]       host_bus_o,
  output logic                  host_bus_oe_n_o,
  output logic      [COL_W-1:0] red_o,
  output logic      [COL_W-1:0] green_o,
  output logic      [COL_W-1:0] blue_o
);
  // two-flop synchronisers on every host-side pin
  logic       rd_s1_ff, rd_s2_ff, wr_s1_ff, wr_s2_ff, wr_s3_ff, rd_s3_ff;
  logic [1:0] sel_s1_ff, sel_s2_ff;
  logic [7:0] dat_s1_ff, dat_s2_ff;

  // synchroniser chain: first stage is read only by the second
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_s1_ff  <= 1'b1;
      rd_s2_ff  <= 1'b1;
      rd_s3_ff  <= 1'b1;
      wr_s1_ff  <= 1'b1;
      wr_s2_ff  <= 1'b1;
      wr_s3_ff  <= 1'b1;
      sel_s1_ff <= 2'h0;
      sel_s2_ff <= 2'h0;
      dat_s1_ff <= 8'h00;
      dat_s2_ff <= 8'h00;
    end else begin
      rd_s1_ff  <= rd_n_i;
      rd_s2_ff  <= rd_s1_ff;
      rd_s3_ff  <= rd_s2_ff;
      wr_s1_ff  <= wr_n_i;
      wr_s2_ff  <= wr_s1_ff;
      wr_s3_ff  <= wr_s2_ff;
      sel_s1_ff <= {reg_select_hi_i, reg_select_lo_i};
      sel_s2_ff <= sel_s1_ff;
      dat_s1_ff <= host_bus_i;
      dat_s2_ff <= dat_s1_ff;
    end
  end

  // data and select are stable around the strobe edge (setup/hold on the pins), so the
  // synchronised copies are coherent when the delayed strobe edge is seen
  wire       wr_done  = wr_s2_ff & ~wr_s3_ff;
  wire       rd_done  = rd_s2_ff & ~rd_s3_ff;
  wire       rd_act   = ~rd_s2_ff & wr_s2_ff;
  wire [1:0] sel      = sel_s2_ff;
  wire       wr_addr  = wr_done & (sel == SEL_ADDR_WR);
  wire       wr_aread = wr_done & (sel == SEL_ADDR_RD);
  wire       wr_pal   = wr_done & (sel == SEL_PALETTE);
  wire       wr_mask  = wr_done & (sel == SEL_MASK);
  wire       rd_pal   = rd_done & (sel == SEL_PALETTE);

  logic [7:0]       addr_ff, nxt_addr, mask_ff;
  logic [1:0]       phase_ff, nxt_phase;
  logic [COL_W-1:0] red_hold_ff, green_hold_ff;
  logic             wmode_ff;

  function automatic logic [1:0] phase_step(input logic [1:0] ph);
    phase_step = (ph == PH_BLUE) ? PH_RED : ph + 2'h1;
  endfunction : phase_step

  wire pal_acc   = wr_pal | rd_pal;
  wire blue_step = pal_acc & (phase_ff == PH_BLUE);
  wire pal_we    = wr_pal & (phase_ff == PH_BLUE);

  // address and phase next values; wrap from FF to 00 is an explicit compare against ADDR_LAST
  always_comb begin
    nxt_addr  = addr_ff;
    nxt_phase = phase_ff;
    if (wr_addr | wr_aread) begin
      nxt_addr  = dat_s2_ff;
      nxt_phase = PH_RED;
    end else if (pal_acc) begin
      nxt_phase = phase_step(phase_ff);
      if (blue_step) begin
        nxt_addr = (addr_ff == ADDR_LAST) ? ADDR_RST : addr_ff + 8'h01;
      end
    end
  end

  // host-side registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_ff       <= ADDR_RST;
      phase_ff      <= PH_RED;
      mask_ff       <= MASK_RST;
      wmode_ff      <= 1'b1;
      red_hold_ff   <= BLANK_LVL;
      green_hold_ff <= BLANK_LVL;
    end else begin
      addr_ff  <= nxt_addr;
      phase_ff <= nxt_phase;
      if (wr_mask) begin
        mask_ff <= dat_s2_ff;
      end
      if (wr_addr | wr_aread) begin
        wmode_ff <= wr_addr;
      end
      if (wr_pal & (phase_ff == PH_RED)) begin
        red_hold_ff <= dat_s2_ff[COL_W-1:0];
      end
      if (wr_pal & (phase_ff == PH_GREEN)) begin
        green_hold_ff <= dat_s2_ff[COL_W-1:0];
      end
    end
  end

  // pixel capture stage
  logic [7:0] pix_ff;
  logic       blank_n_ff, blank_n_d_ff;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pix_ff       <= 8'h00;
      blank_n_ff   <= 1'b0;
      blank_n_d_ff <= 1'b0;
    end else begin
      pix_ff       <= pixel_index_i;
      blank_n_ff   <= blank_n_i;
      blank_n_d_ff <= blank_n_ff;
    end
  end

  // mask gates the index; blanked pixels look at index 00 instead of their own
  wire [7:0] pix_addr = blank_n_ff ? (pix_ff & mask_ff) : 8'h00;

  logic [ENTRY_W-1:0] pix_entry, host_entry;

  cpal_ram u_ram (
    .clk_i     (ref_clk_i),
    .we_i      (pal_we),
    .waddr_i   (addr_ff),
    .wdata_i   ({red_hold_ff, green_hold_ff, dat_s2_ff[COL_W-1:0]}),
    .raddr_a_i (pix_addr),
    .rdata_a_o (pix_entry),
    .raddr_b_i (addr_ff),
    .rdata_b_o (host_entry)
  );

  // colour outputs, blank delayed to match the ram read
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      red_o   <= BLANK_LVL;
      green_o <= BLANK_LVL;
      blue_o  <= BLANK_LVL;
    end else if (!blank_n_d_ff) begin
      red_o   <= BLANK_LVL;
      green_o <= BLANK_LVL;
      blue_o  <= BLANK_LVL;
    end else begin
      red_o   <= pix_entry[17:12];
      green_o <= pix_entry[11:6];
      blue_o  <= pix_entry[5:0];
    end
  end

  // host read data: colour by phase, upper bits zero
  logic [COL_W-1:0] col_sel;
  assign col_sel = (phase_ff == PH_RED)   ? host_entry[17:12] :
                   (phase_ff == PH_GREEN) ? host_entry[11:6] : host_entry[5:0];
  wire [7:0] rd_val = (sel == SEL_PALETTE) ? {UPPER_ZERO, col_sel} :
                      (sel == SEL_MASK)    ? mask_ff : addr_ff;

  // read data registered; a limitation: valid a few clocks after read falls
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_bus_o      <= 8'h00;
      host_bus_oe_n_o <= 1'b1;
    end else begin
      host_bus_o      <= rd_val;
      host_bus_oe_n_o <= ~rd_act;
    end
  end

  wire unused_wmode = wmode_ff;
endmodule : cpal_port
`default_nettype wire

// ==== shared/cpal_pkg.sv ====
package cpal_pkg;
  // select codes on {reg_select_hi, reg_select_lo}
  localparam logic [1:0] SEL_ADDR_WR = 2'h0;
  localparam logic [1:0] SEL_PALETTE = 2'h1;
  localparam logic [1:0] SEL_MASK    = 2'h2;
  localparam logic [1:0] SEL_ADDR_RD = 2'h3;
  // widths
  localparam int PIX_W   = 8;
  localparam int COL_W   = 6;
  localparam int ENTRY_W = 18;
  localparam int DEPTH   = 256;
  // colour phase counter (modulo three)
  localparam logic [1:0] PH_RED   = 2'h0;
  localparam logic [1:0] PH_GREEN = 2'h1;
  localparam logic [1:0] PH_BLUE  = 2'h2;
  // reset values and fixed constants
  localparam logic [7:0] ADDR_RST  = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'hFF;
  localparam logic [5:0] BLANK_LVL = 6'h00;
  localparam logic [7:0] ADDR_LAST = 8'hFF;
  localparam logic [1:0] UPPER_ZERO = 2'h0;
endpackage : cpal_pkg

// ==== hdl/cpal_ram.sv ====
`timescale 1ns/10ps
`default_nettype none
// palette storage: one write port, two registered read ports
module cpal_ram
  import cpal_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         waddr_i,
  input  wire logic [ENTRY_W-1:0] wdata_i,
  input  wire logic [7:0]         raddr_a_i,
  output logic      [ENTRY_W-1:0] rdata_a_o,
  input  wire logic [7:0]         raddr_b_i,
  output logic      [ENTRY_W-1:0] rdata_b_o
);
  logic [ENTRY_W-1:0] mem [DEPTH];

  // no reset on the array; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_a_o <= mem[raddr_a_i];
    rdata_b_o <= mem[raddr_b_i];
  end
endmodule : cpal_ram
`default_nettype wire

// ==== verification/cpal_port_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module cpal_port_asserts
  import cpal_pkg::*;
(
  input wire logic             ref_clk_i,
  input wire logic             sys_rst_i,
  input wire logic [PIX_W-1:0] pixel_index_i,
  input wire logic             blank_n_i,
  input wire logic             rd_n_i,
  input wire logic             wr_n_i,
  input wire logic             reg_select_lo_i,
  input wire logic             reg_select_hi_i,
  input wire logic [7:0]       host_bus_i,
  input wire logic [7:0]       host_bus_o,
  input wire logic             host_bus_oe_n_o,
  input wire logic [COL_W-1:0] red_o,
  input wire logic [COL_W-1:0] green_o,
  input wire logic [COL_W-1:0] blue_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // colour path latency is three edges, blanking wins over any index
  a_blank_black: assert property (!blank_n_i |-> ##3
    {red_o, green_o, blue_o} == 18'h0) else $error("colour not blanked");
  // wr_n high long enough that no palette update is still in flight
  a_pix_steady: assert property (
    (blank_n_i && wr_n_i && $stable(pixel_index_i)) [*8] |->
    $stable({red_o, green_o, blue_o})) else $error("colour moved on steady pixel");
  a_rd_drive: assert property ($fell(rd_n_i) |-> ##[1:5] !host_bus_oe_n_o)
    else $error("bus not driven on read");
  a_rd_release: assert property ($rose(rd_n_i) |-> ##[1:5] host_bus_oe_n_o)
    else $error("bus not released");
  a_idle_quiet: assert property (rd_n_i [*5] |-> host_bus_oe_n_o)
    else $error("bus driven while idle");
  a_rd_held: assert property ((!rd_n_i) [*5] |-> !host_bus_oe_n_o)
    else $error("bus dropped mid read");
  a_rd_steady: assert property ((!rd_n_i) [*6] |-> $stable(host_bus_o))
    else $error("read data moved");
  a_col_upper: assert property ((!rd_n_i) [*6] ##0 {reg_select_hi_i, reg_select_lo_i} ==
    SEL_PALETTE |-> host_bus_o[7:6] == UPPER_ZERO) else $error("colour upper bits set");
endmodule : cpal_port_asserts
bind cpal_port cpal_port_asserts u_chk (.ref_clk_i, .sys_rst_i, .pixel_index_i, .blank_n_i,
  .rd_n_i, .wr_n_i, .reg_select_lo_i, .reg_select_hi_i, .host_bus_i, .host_bus_o,
  .host_bus_oe_n_o, .red_o, .green_o, .blue_o);
`default_nettype wire

// ==== verification/cpal_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cpal_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] bus_rd_i,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic      [1:0] sel_o,
  output logic      [7:0] bus_wr_o
);
  // one strobe at a time, so read and write never overlap
  initial begin
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sel_o = 2'h0;
    bus_wr_o = 8'h00;
  end
  // data and select outlive the rising strobe by three clocks
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk_i) #1;
    sel_o = s;
    bus_wr_o = d;
    wr_n_o = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 wr_n_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 bus_wr_o = ~d; // stale data must not look valid
    repeat (2) @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(posedge clk_i) #1;
    sel_o = s;
    rd_n_o = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 d = bus_rd_i;
    rd_n_o = 1'b1;
    repeat (5) @(posedge clk_i);
  endtask : rd
endmodule : cpal_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import cpal_pkg::*;
;
  logic        ref_clk_i, sys_rst_i, blank_n, rd_n, wr_n, oe_n;
  logic [1:0]  sel;
  logic [7:0]  idx, hbo, hw, bus, hd, seed, mask, a;
  logic [5:0]  r, g, b;
  logic [17:0] pal [DEPTH];
  logic [17:0] exp_q [$];
  logic [7:0]  hexp_q [$];
  int          due_q [$];
  int          cyc, err_count, tests_run;
  assign bus = !oe_n ? hbo : hw; // wire level from both drivers
  cpal_port dut (.ref_clk_i, .sys_rst_i, .pixel_index_i(idx), .blank_n_i(blank_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .reg_select_lo_i(sel[0]), .reg_select_hi_i(sel[1]),
    .host_bus_i(bus), .host_bus_o(hbo), .host_bus_oe_n_o(oe_n), .red_o(r), .green_o(g),
    .blue_o(b));
  cpal_host_model u_host (.clk_i(ref_clk_i), .bus_rd_i(bus), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .sel_o(sel), .bus_wr_o(hw));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    // a note still queued means a result never showed up
    if (exp_q.size() != 0 || hexp_q.size() != 0) err_count++;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // note the expected colour, due two edges after the capture edge
  task automatic pix(input logic [7:0] i, input logic bl);
    @(posedge ref_clk_i) #1;
    idx = i;
    blank_n = bl;
    exp_q.push_back(bl ? pal[i & mask] : 18'h0);
    due_q.push_back(cyc + 3);
  endtask : pix
  task automatic hrd(input logic [1:0] s, input logic [7:0] e);
    hexp_q.push_back(e);
    u_host.rd(s, hd);
  endtask : hrd
  // read watcher: the bus is still driven when the strobe is released, so look then
  always @(posedge rd_n) begin
    if (hexp_q.size() > 0) begin
      chk({10'h0, bus}, {10'h0, hexp_q.pop_front()});
    end
  end
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  // colour watcher, sampling mid-cycle where outputs are settled
  always @(negedge ref_clk_i) begin
    if (due_q.size() > 0 && due_q[0] == cyc) begin
      void'(due_q.pop_front());
      chk({r, g, b}, exp_q.pop_front());
    end
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #(20 * 4000);
    err_count++;
    end_of_test();
  end
  initial begin
    sys_rst_i = 1'b1;
    blank_n = 1'b0;
    idx = 8'h00;
    cyc = 0;
    err_count = 0;
    tests_run = 0;
    seed = 8'h03;
    mask = MASK_RST;
    repeat (6) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    hrd(SEL_MASK, MASK_RST);
    hrd(SEL_ADDR_RD, ADDR_RST);
    $display("test reset values done");
    // three entries across the top, upper bits set to prove they are dropped
    u_host.wr(SEL_ADDR_WR, 8'hFE);
    a = 8'hFE;
    for (int e = 0; e < 3; e++) begin
      for (int c = 0; c < 3; c++) begin
        seed = lfsr(seed);
        u_host.wr(SEL_PALETTE, seed | 8'hC0);
        pal[a][17 - 6 * c -: 6] = seed[5:0];
      end
      a++;
    end
    hrd(SEL_ADDR_RD, 8'h01);
    $display("test palette write done");
    u_host.wr(SEL_ADDR_RD, 8'hFF);
    for (int c = 0; c < 3; c++) hrd(SEL_PALETTE, {2'h0, pal[8'hFF][17 - 6 * c -: 6]});
    hrd(SEL_ADDR_RD, 8'h00);
    $display("test palette read done");
    pix(8'hFE, 1'b1);
    pix(8'h00, 1'b1);
    repeat (10) pix(8'hFF, 1'b1);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      pix(seed, 1'b0);
    end
    $display("test pixel path done");
    // a cleared mask folds every index onto entry 00
    u_host.wr(SEL_MASK, 8'h00);
    mask = 8'h00;
    hrd(SEL_MASK, 8'h00);
    pix(8'hFF, 1'b1);
    pix(lfsr(seed), 1'b1);
    pix(8'h00, 1'b0);
    repeat (5) @(posedge ref_clk_i);
    $display("test mask done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
